/* hw/rtccf_regs.vh */
// Register map, field positions and timing constants for the RTC century and flags block.
// Included by both design files; holds definitions only.
`ifndef RTCCF_REGS_VH
`define RTCCF_REGS_VH

`define RTCCF_ADDR_W         20
`define RTCCF_OFF_STATUS     20'hFFFF0
`define RTCCF_OFF_CENTURY    20'hFFFF1

`define RTCCF_BIT_WDOG       7
`define RTCCF_BIT_ALARM      6
`define RTCCF_BIT_PFAIL      5
`define RTCCF_BIT_OSCILLATOR_FAIL_FLAG       4
`define RTCCF_BIT_CAL        2
`define RTCCF_BIT_WFRZ       1
`define RTCCF_BIT_RFRZ       0

`define RTCCF_CENTURY_RST    8'h00
`define RTCCF_BCD_MAX        4'h9
`define RTCCF_ALARM_FIELDS   4

`define RTCCF_CLK_HZ         125000000
`define RTCCF_OSC_WAIT_MS    5
`define RTCCF_CAL_HZ         512

`endif

/* hw/rtccf_cal_wave.v */
// Square wave generator for calibration output.
// Assumes ref_clk at the rate in the header; half period rounded down.
`timescale 1ns/1ps
`default_nettype none
`include "rtccf_regs.vh"

module rtccf_cal_wave
#(
   parameter integer HALF_CYCLES = `RTCCF_CLK_HZ / (2 * `RTCCF_CAL_HZ)
)
(
   // Clock and reset
   input  wire ref_clk,
   input  wire rst_n,
   // Control
   input  wire enable,
   // Wave
   output reg  wave
);

   reg [31:0] count;

   always @(posedge ref_clk)
   begin
      if (!rst_n || !enable)
      begin
         count <= 32'h0;
         wave  <= 1'b0;
      end
      else if (count == HALF_CYCLES - 1)
      begin
         count <= 32'h0;
         wave  <= ~wave;
      end
      else
      begin
         count <= count + 32'h1;
      end
   end

endmodule

`default_nettype wire

/* hw/rtccf_top.v */
// RTC century counter and status/control register on the parallel memory bus.
// Assumes a synchronous byte bus: rd_stb/wr_stb one-cycle strobes with addr; event inputs are synchronous.
// Behaviour
// - Watchdog reaching zero unrestarted sets the watchdog expired flag.
// - Reading the flag register or power-up clears watchdog, alarm and power-fail flags.
// - Alarm flag sets when time equals alarm in bits 6:0 of every unmasked field; bit 7 of each field is not compared.
// - Mask bit zero includes a field in comparison; one ignores it.
// - Supply dropping below switch threshold sets the power fail flag.
// - Oscillator enabled but not running within 5 ms sets oscillator fail.
// - Oscillator fail flag survives power cycles; a status write with bit 4 zero clears it.
// - Calibration bit one drives 512 Hz wave on interrupt pin.
// - Calibration bit comes up zero after every power-up.
`timescale 1ns/1ps
`default_nettype none
`include "rtccf_regs.vh"

module rtccf_top
#(
   parameter integer OSC_WAIT_CYCLES = (`RTCCF_CLK_HZ / 1000) * `RTCCF_OSC_WAIT_MS,
   parameter integer CAL_HALF_CYCLES = `RTCCF_CLK_HZ / (2 * `RTCCF_CAL_HZ)
)
(
   // Clock and power-up reset
   input  wire                      ref_clk,
   input  wire                      rst_n,
   // Register bus
   input  wire [`RTCCF_ADDR_W-1:0]  addr,
   input  wire                      rd_stb,
   input  wire                      wr_stb,
   input  wire [7:0]                wr_data,
   output reg  [7:0]                rd_data,
   // Events from the rest of the RTC
   input  wire                      wdog_zero,
   input  wire                      supply_low,
   input  wire                      osc_enabled,
   input  wire                      osc_running,
   input  wire                      osc_fail_kept,
   input  wire [`RTCCF_ALARM_FIELDS*8-1:0] time_now,
   input  wire [`RTCCF_ALARM_FIELDS*8-1:0] alarm_set,
   input  wire [`RTCCF_ALARM_FIELDS-1:0]   alarm_mask,
   input  wire                      int_normal,
   // Outputs to counters and pins
   output wire                      int_pin,
   output reg                       write_freeze,
   output reg                       read_freeze,
   output reg                       load_counters,
   output reg  [7:0]                century_count,
   output reg  [7:0]                century_view
);

   reg        watchdog_expired_flag;
   reg        alarm_match_flag;
   reg        power_fail_flag;
   reg        oscillator_fail_flag;
   reg        cal_select;
   reg        osc_check_done;
   reg [31:0] osc_count;
   reg        alarm_hit_q;
   wire       cal_wave;
   wire [`RTCCF_ALARM_FIELDS-1:0] field_ok;

   wire sel_status  = (addr == `RTCCF_OFF_STATUS);
   wire sel_century = (addr == `RTCCF_OFF_CENTURY);
   wire rd_status   = rd_stb && sel_status;
   wire wr_status   = wr_stb && sel_status;
   wire wr_century  = wr_stb && sel_century;

   genvar g;
   generate
      for (g = 0; g < `RTCCF_ALARM_FIELDS; g = g + 1)
      begin : g_field
         assign field_ok[g] = alarm_mask[g] ||
                              (time_now[g*8+6:g*8] == alarm_set[g*8+6:g*8]);
      end
   endgenerate

   wire alarm_hit  = &field_ok;
   wire alarm_rise = alarm_hit && !alarm_hit_q;

   wire [7:0] status_view = {watchdog_expired_flag, alarm_match_flag, power_fail_flag,
                             oscillator_fail_flag, 1'b0, cal_select, write_freeze, read_freeze};

   // Sticky event flags; set wins over read clear
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         watchdog_expired_flag <= 1'b0;
         alarm_match_flag      <= 1'b0;
         power_fail_flag       <= 1'b0;
         alarm_hit_q           <= 1'b0;
      end
      else
      begin
         alarm_hit_q <= alarm_hit;
         if (wdog_zero)
            watchdog_expired_flag <= 1'b1;
         else if (rd_status)
            watchdog_expired_flag <= 1'b0;
         if (alarm_rise)
            alarm_match_flag <= 1'b1;
         else if (rd_status)
            alarm_match_flag <= 1'b0;
         if (supply_low)
            power_fail_flag <= 1'b1;
         else if (rd_status)
            power_fail_flag <= 1'b0;
      end
   end

   // Oscillator check window after power-up
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         osc_count      <= 32'h0;
         osc_check_done <= 1'b0;
      end
      else if (!osc_check_done)
      begin
         if (osc_running || !osc_enabled)
            osc_check_done <= 1'b1;
         else if (osc_count == OSC_WAIT_CYCLES - 1)
            osc_check_done <= 1'b1;
         else
            osc_count <= osc_count + 32'h1;
      end
   end

   wire osc_timeout = !osc_check_done && osc_enabled && !osc_running &&
                      (osc_count == OSC_WAIT_CYCLES - 1);

   // retained value reloaded at power-up, cleared by a status write with bit 4 zero
   reg kept_loaded;
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         oscillator_fail_flag <= 1'b0;
         kept_loaded          <= 1'b0;
      end
      else
      begin
         kept_loaded <= 1'b1;
         if (osc_timeout || (!kept_loaded && osc_fail_kept))
            oscillator_fail_flag <= 1'b1;
         else if (wr_status && !wr_data[`RTCCF_BIT_OSCILLATOR_FAIL_FLAG])
            oscillator_fail_flag <= 1'b0;
      end
   end

   // Control bits and century register
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cal_select    <= 1'b0;
         write_freeze  <= 1'b0;
         read_freeze   <= 1'b0;
         load_counters <= 1'b0;
         century_count <= `RTCCF_CENTURY_RST;
         century_view  <= `RTCCF_CENTURY_RST;
      end
      else
      begin
         load_counters <= 1'b0;
         if (wr_status)
         begin
            cal_select   <= wr_data[`RTCCF_BIT_CAL];
            write_freeze <= wr_data[`RTCCF_BIT_WFRZ];
            read_freeze  <= wr_data[`RTCCF_BIT_RFRZ];
            if (write_freeze && !wr_data[`RTCCF_BIT_WFRZ])
               load_counters <= 1'b1;
         end
         if (wr_century && write_freeze &&
             wr_data[7:4] <= `RTCCF_BCD_MAX && wr_data[3:0] <= `RTCCF_BCD_MAX)
            century_count <= wr_data;
         if (!read_freeze)
            century_view <= century_count;
      end
   end

   // Read data registered on the strobe
   always @(posedge ref_clk)
   begin
      if (!rst_n)
         rd_data <= 8'h00;
      else if (rd_stb)
      begin
         if (sel_status)
            rd_data <= status_view;
         else if (sel_century)
            rd_data <= century_view;
         else
            rd_data <= 8'h00;
      end
   end

   rtccf_cal_wave
   #(
      .HALF_CYCLES (CAL_HALF_CYCLES)
   )
   u_cal
   (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (cal_select),
      .wave    (cal_wave)
   );

   assign int_pin = cal_select ? cal_wave : int_normal;

endmodule

`default_nettype wire

/* dv/rtccf_chk.sv */
// Checker for the RTC century and flags block.
// Sees top ports only; bound into the top below.
`timescale 1ns/1ps
`default_nettype none
module rtccf_chk
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Bus and events
   input wire logic [19:0] addr,
   input wire logic        rd_stb,
   input wire logic        wr_stb,
   input wire logic [7:0]  wr_data,
   input wire logic [7:0]  rd_data,
   input wire logic        wdog_zero,
   input wire logic        supply_low,
   input wire logic        int_normal,
   // Outputs
   input wire logic        int_pin,
   input wire logic        write_freeze,
   input wire logic        read_freeze,
   input wire logic        load_counters,
   input wire logic [7:0]  century_count
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   wire logic rs = rd_stb && addr == 20'hFFFF0;
   wire logic ws = wr_stb && addr == 20'hFFFF0;
   wire logic wc = wr_stb && addr == 20'hFFFF1;
   wire logic quiet = !wdog_zero && !supply_low;
   a_wdog_sets: assert property (wdog_zero ##1 rs |=> rd_data[7])
      else $error("wdog flag");
   a_pfail_sets: assert property ($fell(supply_low) && rs |=> rd_data[5])
      else $error("pfail flag");
   a_read_clears: assert property (
      rs && quiet ##1 quiet ##1 rs && quiet |=> {rd_data[7], rd_data[5]} == 2'h0)
      else $error("flags kept");
   a_cal_off: assert property (ws && !wr_data[2] |=> int_pin == int_normal)
      else $error("int pin");
   a_cal_reset: assert property ($rose(rst_n) |-> int_pin == int_normal)
      else $error("cal after reset");
   a_freeze_bits: assert property (ws |=> {write_freeze, read_freeze} == $past(wr_data[1:0]))
      else $error("freeze bits");
   a_load_pulse: assert property (ws && write_freeze && !wr_data[1] |=> load_counters ##1 !load_counters)
      else $error("load pulse");
   a_cen_refuse: assert property (wc && !write_freeze |=> $stable(century_count))
      else $error("century refuse");
   a_cen_load: assert property (
      wc && write_freeze && wr_data[3:0] <= 4'h9 && wr_data[7:4] <= 4'h9 |=> century_count == $past(wr_data))
      else $error("century load");
endmodule
bind rtccf_top rtccf_chk i_chk (.ref_clk, .rst_n, .addr, .rd_stb, .wr_stb, .wr_data, .rd_data, .wdog_zero,
   .supply_low, .int_normal, .int_pin, .write_freeze, .read_freeze, .load_counters, .century_count);
`default_nettype wire

/* dv/rtccf_host.sv */
// Host processor model on the parallel byte bus.
// One strobe cycle per access; bus shows inverted values when idle.
`timescale 1ns/1ps
`default_nettype none
module rtccf_host
(
   // Clock and read data
   input  wire logic        ref_clk,
   input  wire logic [7:0]  rd_data,
   // Requests
   output var  logic [19:0] addr,
   output var  logic        rd_stb,
   output var  logic        wr_stb,
   output var  logic [7:0]  wr_data
);
   initial
   begin
      addr = 20'h0000F;
      {rd_stb, wr_stb, wr_data} = 10'h000;
   end
   task automatic acc(input logic [19:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      addr = a;
      wr_data = d;
      {wr_stb, rd_stb} = {w, !w};
      @(posedge ref_clk);
      #1;
      q = rd_data;
      {wr_stb, rd_stb} = 2'h0;
      addr = ~a;
      wr_data = ~d;
   endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the RTC century and flags block.
// Host model drives the bus; events are driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        ref_clk, rst_n, wdog_zero, supply_low, osc_enabled, osc_running, osc_fail_kept, int_normal;
   logic        rd_stb, wr_stb, int_pin;
   logic [31:0] time_now, alarm_set;
   logic [3:0]  alarm_mask;
   logic [19:0] addr;
   logic [7:0]  wr_data, rd_data, century_count, q;
   int          bad_count, n_checks;
   localparam int CAL_HALF = 4;
   rtccf_top #(.OSC_WAIT_CYCLES(50), .CAL_HALF_CYCLES(CAL_HALF)) i_dut (.ref_clk, .rst_n, .addr, .rd_stb, .wr_stb,
      .wr_data, .rd_data, .wdog_zero, .supply_low, .osc_enabled, .osc_running, .osc_fail_kept, .time_now,
      .alarm_set, .alarm_mask, .int_normal, .int_pin, .write_freeze(), .read_freeze(), .load_counters(),
      .century_count, .century_view());
   rtccf_host i_host (.ref_clk, .rd_data, .addr, .rd_stb, .wr_stb, .wr_data);
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [19:0] a, input logic [7:0] d);
      i_host.acc(a, d, 1'b1, q);
   endtask
   task rd(input logic [19:0] a);
      i_host.acc(a, 8'h00, 1'b0, q);
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task do_reset;
      rst_n = 0;
      tick(8);
      rst_n = 1;
   endtask
   task t_osc;
      tick(60);
      rd(20'hFFFF0);
      chk(q, 8'h10);
      osc_running = 1;
      wr(20'hFFFF0, 8'h10);
      rd(20'hFFFF0);
      chk(q, 8'h10);
      wr(20'hFFFF0, 8'h00);
      rd(20'hFFFF0);
      chk(q, 8'h00);
      wr(20'hFFFF0, 8'h04);
      osc_fail_kept = 1;
      do_reset;
      rd(20'hFFFF0);
      chk(q, 8'h10);
      wr(20'hFFFF0, 8'h00);
      $display("osc test done");
   endtask
   task t_flags;
      time_now = 32'h00000501;
      rd(20'hFFFF0);
      chk(q, 8'h00);
      alarm_mask = 4'hE;
      {wdog_zero, supply_low} = 2'h3;
      fork
         rd(20'hFFFF0);
         begin
            tick(1);
            {wdog_zero, supply_low} = 2'h0;
         end
      join
      chk(q, 8'hE0);
      rd(20'hFFFF0);
      chk(q, 8'h00);
      $display("flags test done");
   endtask
   task t_cen;
      wr(20'hFFFF1, 8'h21);
      chk(century_count, 8'h00);
      wr(20'hFFFF0, 8'h02);
      wr(20'hFFFF1, 8'h21);
      chk(century_count, 8'h21);
      wr(20'hFFFF1, 8'h9A);
      chk(century_count, 8'h21);
      wr(20'hFFFF0, 8'h00);
      tick(2);
      rd(20'hFFFF1);
      chk(q, 8'h21);
      wr(20'hFFFF0, 8'h03);
      wr(20'hFFFF1, 8'h45);
      rd(20'hFFFF1);
      chk(q, 8'h21);
      wr(20'hFFFF0, 8'h00);
      tick(2);
      rd(20'hFFFF1);
      chk(q, 8'h45);
      rd(20'h12345);
      chk(q, 8'h00);
      $display("century test done");
   endtask
   task t_cal;
      wr(20'hFFFF0, 8'h04);
      int_normal = 1;
      tick(1);
      chk({7'h00, int_pin}, 8'h00);
      tick(CAL_HALF - 1);
      chk({7'h00, int_pin}, 8'h01);
      tick(CAL_HALF);
      chk({7'h00, int_pin}, 8'h00);
      wr(20'hFFFF0, 8'h00);
      chk({7'h00, int_pin}, 8'h01);
      $display("cal test done");
   endtask
   task end_of_test;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      ref_clk = 0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial
   begin
      #20000;
      bad_count++;
      end_of_test;
   end
   initial
   begin
      {wdog_zero, supply_low, osc_running, osc_fail_kept, int_normal} = 5'h01;
      osc_enabled = 1;
      time_now = 32'h0;
      alarm_set = 32'h1;
      alarm_mask = 4'h0;
      do_reset;
      t_osc;
      t_flags;
      t_cen;
      t_cal;
      end_of_test;
   end
endmodule
`default_nettype wire
